// ==== include/mws_pkg.sv ====
// Package of constants and types for the writable microstore write port.
// ============================================================================
// Behaviour
// - Store holds 1024 words of 96 data bits plus 3 group parity bits.
// - Without inversion, each stored 32-bit group gets even parity.
// - A write is a pointer-load cycle followed by a data cycle.
// - Data cycle may come any time after pointer load; pointer is held.
// - Written data is stored exactly as seen on the internal bus.
// - Pointer bits 14:13 load from bus and count modulo 3 per group.
// - After each data write group advances; on wrap word address increments.
// - Pointer bit 15 set writes inverted parity, clear writes even parity.
// - Group 00 selects bits 31:0, 01 bits 63:32, 10 bits 95:64, 11 lowest.
// - Bank-half jumper removed places module low 4K, installed upper 4K.
// - Segment jumpers two to four pick which 1K inside the chosen half.
// - A presence-read strobe makes the module drive its presence bits.
// - Presence uses bus bits 7:0, only the module's own segment bit set.
// - Microcode bus outputs are three-state, driven only when selected.
package mws_pkg;
  localparam int MWS_WORDS = 1024;
  localparam int MWS_AW = 10;
  localparam int MWS_DW = 96;
  localparam int MWS_PW = 3;
  localparam int MWS_GW = 32;
  localparam int MWS_SEGS = 8;
  // Pointer field positions.
  localparam int MWS_PTR_INV_BIT = 15;
  localparam int MWS_PTR_GRP_HI = 14;
  localparam int MWS_PTR_GRP_LO = 13;
  localparam int MWS_PTR_ADR_HI = 12;
  localparam logic [1:0] MWS_GRP_A = 2'h0;
  localparam logic [1:0] MWS_GRP_B = 2'h1;
  localparam logic [1:0] MWS_GRP_C = 2'h2;
  localparam logic [15:0] MWS_PTR_RESET = 16'h0000;
  // Microcode address field positions for the segment compare.
  localparam int MWS_UA_HALF_BIT = 12;
  localparam int MWS_UA_SEG_HI = 11;
  localparam int MWS_UA_SEG_LO = 10;
  typedef struct packed {
    logic [15:0] ptr_r;
  } mws_state_t;
endpackage : mws_pkg

// ==== verilog/mws_store_array.sv ====
// Storage array of 1024 words of 99 bits with per-group write.
`timescale 1ns/1ns
`default_nettype none
module mws_store_array
  import mws_pkg::*;
(
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [MWS_AW-1:0] wr_addr,
  input wire logic [1:0] wr_grp,
  input wire logic [MWS_GW-1:0] wr_data,
  input wire logic wr_par,
  input wire logic [MWS_AW-1:0] rd_addr,
  output logic [MWS_DW+MWS_PW-1:0] rd_word
);
  // ==========================================================================
  // Array
  logic [MWS_DW+MWS_PW-1:0] mem [MWS_WORDS];
  // Each group is a separate write lane; code 11 falls back to group A.
  genvar g;
  generate
    for (g = 0; g < MWS_PW; g++) begin : g_lane
      always_ff @(posedge mclk) begin
        if (wr_en && (wr_grp == 2'(g) || (g == 0 && wr_grp == 2'h3))) begin
          mem[wr_addr][g*MWS_GW +: MWS_GW] <= wr_data;
          mem[wr_addr][MWS_DW+g] <= wr_par;
        end
      end
    end
  endgenerate
  // Registered read, as a synchronous RAM would give it.
  always_ff @(posedge mclk) begin
    rd_word <= mem[rd_addr];
  end
endmodule : mws_store_array
`default_nettype wire

// ==== verilog/mws_write_port.sv ====
// Write port, pointer and slot logic for one writable microstore module.
`timescale 1ns/1ns
`default_nettype none
module mws_write_port
  import mws_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [31:0] internal_data_bus_in,
  output logic [31:0] internal_data_bus_out,
  output logic [31:0] internal_data_bus_oe_n,
  input wire logic ptr_load,
  input wire logic data_write,
  input wire logic presence_read,
  input wire logic bank_half_jumper_n,
  input wire logic segment_jumper_one_n,
  input wire logic segment_jumper_two_n,
  input wire logic segment_jumper_three_n,
  input wire logic segment_jumper_four_n,
  input wire logic [12:0] micro_addr,
  output logic [MWS_DW+MWS_PW-1:0] microcode_bus_out,
  output logic [MWS_DW+MWS_PW-1:0] microcode_bus_oe_n,
  output logic [15:0] write_pointer
);
  // ==========================================================================
  // Theory of operation
  //
  // This module is one writable slice of the microcode store. It holds 1024
  // words. Each word is three 32-bit groups plus one parity bit per group.
  // The processor can only move 32 bits per cycle on its internal bus, so
  // each word is filled in three steps, one group at a time.
  //
  // Filling words:
  //   1. A pointer-load cycle copies the low half of the bus into the
  //      16-bit write pointer. Bit 15 picks inverted parity. Bits 14:13 pick
  //      the group that the next data cycle fills. Bits 12:0 are the word.
  //   2. Each data cycle writes the bus into the selected group of the
  //      selected word, together with the group's parity bit.
  //   3. After a data cycle the group field steps A, B, C. From C it goes
  //      back to A and the word address steps by one, so a caller can
  //      stream whole words with a single pointer load.
  //
  // The pointer is kept for as long as needed between the load and the
  // first data cycle. Nothing times out, because the processor may do any
  // amount of other work in between.
  //
  // The group code 11 has no group of its own. It is treated as group A and
  // wraps to the next word, which is the least surprising choice for a
  // caller that loads a bad code; it costs nothing in logic.
  //
  // When a pointer load and a data cycle fall in the same cycle, the load
  // wins and the data is dropped. A fresh load always starts a new fill, so
  // a half-finished group stepping must not run on after it.
  //
  // Parity:
  //   The parity bit makes the 33-bit field of a group hold an even number
  //   of ones. With bit 15 of the pointer set, the bit is flipped instead.
  //   That lets software plant a bad word on purpose to test the checker.
  //   Data bits are never inverted; only the parity bit is.
  //
  // Placement:
  //   Five jumper pins place the module in one of eight 1K segments. One
  //   pin picks the half; three pins pick the segment in that half, with
  //   the highest removed pin taking priority. The first segment pin has no
  //   known role and is only synchronised. The pins may move at any time,
  //   so they pass two flops before anything reads them.
  //
  // Fetch side:
  //   The array read is registered, like a synchronous RAM. The segment
  //   match is registered too, so the enables line up with the data that
  //   they release. The bus drivers are enabled only for a hit.
  //
  // Presence read:
  //   A presence-read strobe makes the module drive one bit of the low byte
  //   of the internal bus, the bit of its own segment, for one cycle. All
  //   other bits stay released, so several modules can answer together and
  //   each one's bit reaches the reader.
  //
  // Limitations:
  //   - The caller must not write a module in a cycle in which it fetches
  //     from that module; the array has one write and one read port only
  //     and does not arbitrate between them.
  //   - Array content is undefined until written.
  //   - The pointer reset value is a local choice; software always loads the
  //     pointer before it writes.
  // ==========================================================================
  // Jumper synchronisers
  // Jumpers are pins, so they pass two flops; installed means pin low.
  // The flops preset to the removed level, so a module comes out of reset
  // in a known segment instead of a random one.
  logic [4:0] jmp_s1_r, jmp_s2_r;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      jmp_s1_r <= 5'h1f;
      jmp_s2_r <= 5'h1f;
    end else begin
      jmp_s1_r <= {bank_half_jumper_n, segment_jumper_four_n, segment_jumper_three_n,
                   segment_jumper_two_n, segment_jumper_one_n};
      jmp_s2_r <= jmp_s1_r;
    end
  end
  logic half_up;
  logic [1:0] seg_sel;
  logic [2:0] seg_num;
  assign half_up = ~jmp_s2_r[4];
  // The first jumper has no known role and is ignored.
  always_comb begin
    if (jmp_s2_r[3]) seg_sel = 2'h3;
    else if (jmp_s2_r[2]) seg_sel = 2'h2;
    else if (jmp_s2_r[1]) seg_sel = 2'h1;
    else seg_sel = 2'h0;
  end
  assign seg_num = {half_up, seg_sel};

  // ==========================================================================
  // Pointer state
  mws_state_t st_r, st_nxt;
  logic [1:0] grp;
  logic [12:0] wadr;
  logic par_inv;
  logic [31:0] wdata;
  logic wpar;
  assign grp = st_r.ptr_r[MWS_PTR_GRP_HI:MWS_PTR_GRP_LO];
  assign wadr = st_r.ptr_r[MWS_PTR_ADR_HI:0];
  assign par_inv = st_r.ptr_r[MWS_PTR_INV_BIT];
  assign wdata = internal_data_bus_in;
  // Even parity makes the 33-bit field hold an even count of ones.
  assign wpar = (^wdata) ^ par_inv;

  // Pointer load wins over a data write in the same cycle, since a new
  // pointer always restarts a fill sequence.
  always_comb begin
    st_nxt = st_r;
    if (ptr_load) begin
      st_nxt.ptr_r = internal_data_bus_in[15:0];
    end else if (data_write) begin
      if (grp == MWS_GRP_C || grp == 2'h3) begin
        st_nxt.ptr_r[MWS_PTR_GRP_HI:MWS_PTR_GRP_LO] = MWS_GRP_A;
        st_nxt.ptr_r[MWS_PTR_ADR_HI:0] = wadr + 13'h1;
      end else begin
        st_nxt.ptr_r[MWS_PTR_GRP_HI:MWS_PTR_GRP_LO] = grp + 2'h1;
      end
    end
  end
  // Pointer holds between the load and the data cycle with no timeout.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) st_r <= MWS_PTR_RESET;
    else st_r <= st_nxt;
  end
  assign write_pointer = st_r.ptr_r;

  // ==========================================================================
  // Storage array
  logic [MWS_DW+MWS_PW-1:0] rd_word;
  logic ram_we;
  assign ram_we = data_write && !ptr_load;
  mws_store_array u_array (
    .mclk(mclk),
    .wr_en(ram_we),
    .wr_addr(wadr[MWS_AW-1:0]),
    .wr_grp(grp),
    .wr_data(wdata),
    .wr_par(wpar),
    .rd_addr(micro_addr[MWS_AW-1:0]),
    .rd_word(rd_word)
  );

  // ==========================================================================
  // Bus drivers
  logic sel_r, pres_r;
  logic [7:0] pres_bits_r;
  logic [7:0] pres_nxt;
  always_comb begin
    pres_nxt = 8'h00;
    pres_nxt[seg_num] = 1'b1;
  end
  // The fetch select is registered to line up with the registered read.
  // The presence byte is registered too, so the bus sees a clean value for
  // the whole cycle in which it is enabled.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sel_r <= 1'b0;
      pres_r <= 1'b0;
      pres_bits_r <= 8'h00;
    end else begin
      sel_r <= ({micro_addr[MWS_UA_HALF_BIT], micro_addr[MWS_UA_SEG_HI:MWS_UA_SEG_LO]}
                == seg_num);
      pres_r <= presence_read;
      pres_bits_r <= pres_nxt;
    end
  end
  assign microcode_bus_out = rd_word;
  assign microcode_bus_oe_n = {(MWS_DW+MWS_PW){~sel_r}};
  assign internal_data_bus_out = {24'h000000, pres_bits_r};
  // Only our own bit is driven so other modules can share the low byte.
  assign internal_data_bus_oe_n = {24'hffffff, ~(pres_bits_r & {8{pres_r}})};

  // ==========================================================================
  // Checks
  chk_grp_adv: assert property (@(posedge mclk) disable iff (reset)
    (data_write && !ptr_load && grp == MWS_GRP_A) |=> (grp == MWS_GRP_B && $stable(wadr)))
    else $error("group did not advance");
  chk_word_inc: assert property (@(posedge mclk) disable iff (reset)
    (data_write && !ptr_load && grp == MWS_GRP_C) |=> (grp == MWS_GRP_A
      && wadr == $past(wadr) + 13'h1))
    else $error("word address did not increment");
  chk_ptr_load: assert property (@(posedge mclk) disable iff (reset)
    ptr_load |=> write_pointer == $past(internal_data_bus_in[15:0]))
    else $error("pointer not loaded");
  chk_ptr_hold: assert property (@(posedge mclk) disable iff (reset)
    (!ptr_load && !data_write) |=> $stable(write_pointer))
    else $error("pointer changed while idle");
  chk_par_even: assert property (@(posedge mclk) disable iff (reset)
    (ram_we && !par_inv) |-> ^{wdata, wpar} == 1'b0)
    else $error("parity not even");
  chk_par_inv: assert property (@(posedge mclk) disable iff (reset)
    (ram_we && par_inv) |-> ^{wdata, wpar} == 1'b1)
    else $error("parity not inverted");
  chk_no_store: assert property (@(posedge mclk) disable iff (reset)
    ptr_load |-> !ram_we)
    else $error("array written on pointer load");
  chk_pres_one: assert property (@(posedge mclk) disable iff (reset)
    $past(presence_read) |-> $countones(~internal_data_bus_oe_n) == 1)
    else $error("presence not single bit");
  chk_bus_sel: assert property (@(posedge mclk) disable iff (reset)
    !sel_r |-> &microcode_bus_oe_n)
    else $error("bus driven while unselected");

  // Group stepping, group code 11 and the parity mode across data cycles.
  chk_grp_c_adv: assert property (@(posedge mclk) disable iff (reset)
    (data_write && !ptr_load && grp == MWS_GRP_B) |=> (grp == MWS_GRP_C && $stable(wadr)))
    else $error("group did not reach the third group");
  chk_grp_odd_wrap: assert property (@(posedge mclk) disable iff (reset)
    (data_write && !ptr_load && grp == 2'h3) |=> (grp == MWS_GRP_A && wadr == $past(wadr) + 13'h1))
    else $error("group code three did not wrap");
  chk_grp_legal: assert property (@(posedge mclk) disable iff (reset)
    (data_write && !ptr_load) |=> grp != 2'h3)
    else $error("group counter left its three states");
  chk_inv_keep: assert property (@(posedge mclk) disable iff (reset)
    (data_write && !ptr_load) |=> $stable(par_inv))
    else $error("parity mode changed on a data cycle");

  // Pointer loads take each field from the bus.
  chk_inv_load: assert property (@(posedge mclk) disable iff (reset)
    ptr_load |=> par_inv == $past(internal_data_bus_in[MWS_PTR_INV_BIT]))
    else $error("parity mode not loaded");
  chk_grp_load: assert property (@(posedge mclk) disable iff (reset)
    ptr_load |=> grp == $past(internal_data_bus_in[MWS_PTR_GRP_HI:MWS_PTR_GRP_LO]))
    else $error("group field not loaded");
  chk_load_wins: assert property (@(posedge mclk) disable iff (reset)
    (ptr_load && data_write) |=> write_pointer == $past(internal_data_bus_in[15:0]))
    else $error("data cycle beat a pointer load");

  // Array writes happen only on data cycles and carry the bus unchanged.
  chk_no_we_idle: assert property (@(posedge mclk) disable iff (reset)
    !data_write |-> !ram_we)
    else $error("array written without a data cycle");
  chk_data_true: assert property (@(posedge mclk) disable iff (reset)
    ram_we |-> wdata == internal_data_bus_in)
    else $error("written data differs from the bus");

  // Presence answer on the internal bus.
  chk_pres_idle: assert property (@(posedge mclk) disable iff (reset)
    !$past(presence_read) |-> &internal_data_bus_oe_n)
    else $error("internal bus driven without a presence read");
  chk_pres_upper: assert property (@(posedge mclk) disable iff (reset)
    &internal_data_bus_oe_n[31:8] && internal_data_bus_out[31:8] == 24'h000000)
    else $error("presence answer outside the low byte");

  // Fetch-side select follows the segment compare one cycle later.
  chk_sel_drive: assert property (@(posedge mclk) disable iff (reset)
    sel_r |-> microcode_bus_oe_n == '0)
    else $error("bus not driven while selected");
  chk_sel_hit: assert property (@(posedge mclk) disable iff (reset)
    ({micro_addr[MWS_UA_HALF_BIT], micro_addr[MWS_UA_SEG_HI:MWS_UA_SEG_LO]} == seg_num) |=> sel_r)
    else $error("own segment not selected");
  chk_sel_miss: assert property (@(posedge mclk) disable iff (reset)
    ({micro_addr[MWS_UA_HALF_BIT], micro_addr[MWS_UA_SEG_HI:MWS_UA_SEG_LO]} != seg_num) |=> !sel_r)
    else $error("foreign segment selected");

  // Jumper decode and the synchroniser path.
  chk_seg_first: assert property (@(posedge mclk) disable iff (reset)
    (jmp_s2_r[3:1] == 3'h0) |-> seg_sel == 2'h0)
    else $error("first segment not decoded");
  chk_seg_second: assert property (@(posedge mclk) disable iff (reset)
    (jmp_s2_r[3:1] == 3'h1) |-> seg_sel == 2'h1)
    else $error("second segment not decoded");
  chk_seg_third: assert property (@(posedge mclk) disable iff (reset)
    (jmp_s2_r[3:2] == 2'h1) |-> seg_sel == 2'h2)
    else $error("third segment not decoded");
  chk_seg_fourth: assert property (@(posedge mclk) disable iff (reset)
    jmp_s2_r[3] |-> seg_sel == 2'h3)
    else $error("fourth segment not decoded");
  chk_sync_path: assert property (@(posedge mclk) disable iff (reset)
    jmp_s2_r == $past(jmp_s1_r))
    else $error("jumper synchroniser skipped a stage");
endmodule : mws_write_port
`default_nettype wire

// ==== tb/mws_console_model.sv ====
// Console and micro-sequencer model that drives the write port's bus side.
`timescale 1ns/1ns
`default_nettype none
module mws_console_model (
  input wire logic mclk,
  input wire logic [1:0] cmd,
  input wire logic [31:0] cmd_val,
  input wire logic [12:0] fetch_addr,
  output logic [31:0] bus,
  output logic ptr_load,
  output logic data_write,
  output logic presence_read,
  output logic [12:0] micro_addr
);
  // ==========================================================================
  // Bus and strobes
  logic [31:0] last_r;
  // An idle bus shows the inverse of its last value, so stale data never passes.
  always @(posedge mclk) begin
    if (cmd != 2'h0) last_r <= cmd_val;
  end
  // Pointer load first, then one data write per group.
  assign ptr_load = (cmd == 2'h1);
  assign data_write = (cmd == 2'h2);
  assign presence_read = (cmd == 2'h3);
  assign bus = (cmd != 2'h0) ? cmd_val : ~last_r;
  // A write moves the fetch to the other half, away from the module written.
  assign micro_addr = data_write ? (fetch_addr ^ 13'h1000) : fetch_addr;
endmodule : mws_console_model
`default_nettype wire

// ==== tb/microstore_write_port_bench.sv ====
// Self-checking bench for the writable microstore write port.
`timescale 1ns/1ns
`default_nettype none
module microstore_write_port_bench;
  import mws_pkg::*;
  // ==========================================================================
  // Signals
  logic mclk = 0;
  logic reset = 1;
  logic [1:0] cmd = 0;
  logic [1:0] fk = 0;
  logic [1:0] seen_f = 0;
  logic [31:0] val = 0;
  logic [12:0] fa = 0;
  logic hj_n = 0, j1_n = 0, j2_n = 0, j3_n = 0, j4_n = 0, seen_p = 0, seen_s = 0;
  wire [31:0] bus, ido, idoe;
  wire pl_w, dw_w, pr_w;
  wire [12:0] ua;
  wire [98:0] mco, mcoe;
  wire [15:0] wp;
  logic [98:0] qp[$], qs[$], qo[$], qd[$];
  int n_mismatch = 0;
  int n_compared = 0;
  logic [31:0] rs = 32'h837729e7;
  mws_console_model i_mws_console_model (.mclk(mclk), .cmd(cmd), .cmd_val(val),
    .fetch_addr(fa), .bus(bus), .ptr_load(pl_w), .data_write(dw_w),
    .presence_read(pr_w), .micro_addr(ua));
  mws_write_port i_mws_write_port (.mclk(mclk), .reset(reset), .internal_data_bus_in(bus),
    .internal_data_bus_out(ido), .internal_data_bus_oe_n(idoe), .ptr_load(pl_w),
    .data_write(dw_w), .presence_read(pr_w), .bank_half_jumper_n(hj_n),
    .segment_jumper_one_n(j1_n), .segment_jumper_two_n(j2_n),
    .segment_jumper_three_n(j3_n), .segment_jumper_four_n(j4_n), .micro_addr(ua),
    .microcode_bus_out(mco), .microcode_bus_oe_n(mcoe), .write_pointer(wp));
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  task check(input logic [98:0] seen, input logic [98:0] exp, input string nm);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // One cycle of requests; callers idle explicitly, so no signal is set twice at an edge.
  task cyc(input logic [1:0] c, input logic [31:0] v, input logic [1:0] k,
           input logic [12:0] a);
    cmd <= c;
    val <= v;
    fk <= k;
    fa <= a;
    @(posedge mclk);
  endtask : cyc
  // ==========================================================================
  // Clock, watchdog and result watcher
  initial forever #25 mclk = ~mclk;
  initial begin
    repeat (2000) @(posedge mclk);
    n_mismatch++;
    give_verdict();
  end
  // Results show one cycle after their request, so note which ones are due.
  always @(posedge mclk) begin
    seen_p <= pl_w | dw_w;
    seen_s <= pr_w;
    seen_f <= fk;
  end
  // Compare on the falling edge, where the registered outputs have settled.
  always @(negedge mclk) begin
    if (seen_p && qp.size() > 0) check(99'(wp), qp.pop_front(), "pointer");
    if (seen_s && qs.size() > 0) check({ido, idoe}, qs.pop_front(), "presence");
    if (seen_f != 0 && qo.size() > 0) check(mcoe, qo.pop_front(), "enable");
    if (seen_f == 2'h2 && qd.size() > 0) check(mco, qd.pop_front(), "word");
  end
  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [31:0] d [3];
    logic [1:0] s;
    logic [9:0] w;
    logic [12:0] a;
    logic [98:0] exp;
    repeat (2) @(posedge mclk);
    reset <= 0;
    // Every half and segment, with don't-care jumpers random.
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      s = 2'(i ^ 1);
      hj_n <= ((i ^ 1) < 4);
      j4_n <= (s == 2'h3);
      j3_n <= (s == 2'h2) | ((s == 2'h3) & r[0]);
      j2_n <= (s == 2'h1) | (s[1] & r[1]);
      j1_n <= r[2];
      repeat (4) cyc(0, 0, 0, 0);
      qs.push_back({32'h1 << (i ^ 1), ~(32'h1 << (i ^ 1))});
      cyc(3, rnd(), 0, 0);
    end
    r = rnd();
    w = r[9:0];
    a = {1'b1, 2'h2, w};
    qp.push_back({3'h0, 3'h0, w});
    cyc(1, {19'h0, w}, 0, a);
    repeat (3) cyc(0, 0, 0, a); // Pointer must be held.
    for (int g = 0; g < 3; g++) begin
      d[g] = rnd();
      qp.push_back(g < 2 ? {1'b0, 2'(g + 1), 3'h0, w} : {3'h0, ({3'h0, w} + 13'h1)});
      cyc(2, d[g], 0, a);
    end
    // Even parity, one bit per group.
    exp = {^d[2], ^d[1], ^d[0], d[2], d[1], d[0]};
    qo.push_back(99'h0);
    qd.push_back(exp);
    cyc(0, 0, 2, a);
    qo.push_back({99{1'b1}});
    cyc(0, 0, 1, {1'b1, 2'h1, w});
    // Group code three with inverted parity, after a pointer-only cycle.
    qp.push_back({1'b1, 2'h3, 3'h0, w});
    cyc(1, {16'h0, 1'b1, 2'h3, 3'h0, w}, 0, a);
    qo.push_back(99'h0);
    qd.push_back(exp);
    cyc(0, 0, 2, a);
    d[0] = rnd();
    qp.push_back({1'b1, 2'h0, ({3'h0, w} + 13'h1)});
    cyc(2, d[0], 0, a);
    qo.push_back(99'h0);
    qd.push_back({^d[2], ^d[1], ~^d[0], d[2], d[1], d[0]});
    cyc(0, 0, 2, a);
    repeat (3) cyc(0, 0, 0, a);
    give_verdict();
  end
endmodule : microstore_write_port_bench
`default_nettype wire
